// ### inc/scmc_defs.svh
// Constants of the system clock mode controller: offsets, fields, resets, timing.
// Assumes a 32-bit Avalon-MM slave with byte addresses and a 100 MHz clk.
`ifndef SCMC_DEFS_SVH
`define SCMC_DEFS_SVH

// ============================================================
// Register offsets (byte addresses)
`define SCMC_OFS_CTRL2       4'h0
`define SCMC_OFS_TBCTRL      4'h4
`define SCMC_OFS_CTRL1       4'h8
`define SCMC_OFS_STATUS      4'hc

// ============================================================
// Field positions of system_control_two
`define SCMC_BIT_HIGH_OSC    7
`define SCMC_BIT_LOW_OSC     6
`define SCMC_BIT_MAIN_SEL    5
`define SCMC_BIT_IDLE        4
`define SCMC_BIT_TG_HALT     2
// Field positions of time_base_control
`define SCMC_BIT_TB_EN       7
`define SCMC_BIT_DV7_SEL     4
`define SCMC_TB_SRC_MSB      2
// Field positions of control one
`define SCMC_BIT_STOP        7
`define SCMC_BIT_RET_SLOW    5

// ============================================================
// Reset values
`define SCMC_RST_CTRL2       8'h80
`define SCMC_RST_TBCTRL      8'h00

// ============================================================
// Timing and divider structure
`define SCMC_PRE_STAGES      2
`define SCMC_DIV_LO_STAGES   6
`define SCMC_DIV_HI_STAGES   15
`define SCMC_TB_BASE_STAGE   6
`define SCMC_STATES_PER_MC   4
`define SCMC_MAX_INSTR_MC    10
`define SCMC_WARMUP_CYCLES   16'd2048

`endif

// ### inc/scmc_pkg.sv
// Types of the system clock mode controller.
// Assumes scmc_defs.svh supplies the numeric constants.
package scmc_pkg;

    // ============================================================
    // Operating modes
    typedef enum logic [3:0] {
        SCMC_FAST_SINGLE_RUN,
        SCMC_FAST_SINGLE_IDLE,
        SCMC_DEEP_IDLE,
        SCMC_FAST_DUAL_RUN,
        SCMC_FAST_DUAL_IDLE,
        SCMC_SLOW_DUAL_RUN,
        SCMC_SLOW_LOW_ONLY,
        SCMC_SLEEP,
        SCMC_STOP,
        SCMC_WARMUP
    } scmc_mode_e;

endpackage

// ### src/scmc_divider.sv
// Chain of binary divider stages advanced by an input tick.
// Assumes tick_in is a one-cycle pulse on clk; clear wins over the tick.
`timescale 1ns/1ps
module scmc_divider
    import scmc_pkg::*;
#(
    parameter int STAGES = 6
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              clear,
    input  wire logic              tick_in,
    output logic      [STAGES-1:0] stages,
    output logic                   tick_out
);

    typedef struct packed {
        logic [STAGES-1:0] cnt;
        logic              carry;
    } scmc_div_s;

    scmc_div_s st_q;
    scmc_div_s st_d;

    // ============================================================
    // Next state
    always_comb begin
        st_d       = st_q;
        st_d.carry = 1'b0;
        if (clear) begin
            st_d.cnt = '0;
        end else if (tick_in) begin
            st_d.cnt   = st_q.cnt + 1'b1;
            // Last stage falls: the next stage gets its clock
            st_d.carry = &st_q.cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign stages   = st_q.cnt;
    assign tick_out = st_q.carry;

endmodule

// ### src/scmc_top.sv
// System clock mode controller: prescaler, divider, machine cycles, mode control.
// Assumes crystal clocks arrive as slow pins sampled by clk, and the CPU
// side (interrupt enables, request, instruction length) runs on clk.
//
// Contract
// [RQ1] Timing generator: two-stage prescaler, twenty-one-stage divider, machine cycle counters.
// [RQ2] Prescaler and divider clear on reset and on STOP entry or exit.
// [RQ3] Stage seven clock picked from mode, main select and stage-seven select.
// [RQ4] Slow and sleep modes feed low clock to stage seven directly.
// [RQ5] Warm-up after STOP from fast run feeds stage six into seven.
// [RQ6] Software never sets stage-seven select in single-clock mode.
// [RQ7] Software sets stage-seven select only once low oscillator is stable.
// [RQ8] Machine cycle is four states S0 to S3, one main clock each.
// [RQ9] Instructions last one to ten machine cycles.
// [RQ10] Single-clock: only high oscillator, low pins are ports, cycle is four fc.
// [RQ11] Reset leaves the device in fast single-clock run.
// [RQ12] Idle field enters fast single idle; CPU stops, peripherals run.
// [RQ13] Any interrupt ends fast idle; serviced if master enable, else continue.
// [RQ14] Halt field stops all but time base; time-base source fall resumes.
// [RQ15] Deep idle returns to fast run always; interrupt needs three enables.
// [RQ16] Deep idle entered with time base enabled sets its latch on return.
// [RQ17] Dual-clock: both oscillators run; main clock fast or slow by mode.
// [RQ18] Slow and sleep machine cycle equals four low clock periods.
// [RQ19] Software turns low oscillator on early before dual-clock modes.
// [RQ20] Main select one goes to slow dual run; zero returns to fast dual.
// [RQ21] Clearing high oscillator enable in slow dual run enters low-only slow.
// [RQ22] Software keeps low oscillator enabled during slow dual run.
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "scmc_defs.svh"
module scmc_top
    import scmc_pkg::*;
#(
    parameter logic [15:0] WARMUP_CYCLES = `SCMC_WARMUP_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Avalon-MM slave
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Crystal clock pins
    input  wire logic        high_crystal_in,
    input  wire logic        low_crystal_in,
    input  wire logic        stop_release_pin,
    // CPU side
    input  wire logic        interrupt_master_enable,
    input  wire logic        time_base_int_enable,
    input  wire logic        irq_pending,
    input  wire logic [3:0]  instr_cycles,
    // Status outputs
    output logic             high_osc_run,
    output logic             low_osc_run,
    output logic             low_pins_as_port,
    output logic             cpu_clock_enable,
    output logic             periph_clock_enable,
    output logic [1:0]       machine_state,
    output logic             instr_done,
    output logic             wake_service,
    output logic             wake_continue,
    output logic             time_base_int_latch,
    output logic [20:0]      divider_stages
);

    typedef struct packed {
        logic [2:0]  hi_sync;
        logic [2:0]  lo_sync;
        logic [1:0]  rel_sync;
        scmc_mode_e  mode;
        scmc_mode_e  ret_mode;
        logic        high_osc_enable;
        logic        low_osc_enable;
        logic        main_clock_select;
        logic        idle_req;
        logic        timing_gen_halt;
        logic        time_base_enable;
        logic        stage_seven_clock_select;
        logic [2:0]  time_base_source_select;
        logic        stop_req;
        logic        ret_slow;
        logic        warm_fast;
        logic        tb_pend;
        logic        tb_prev;
        logic [15:0] warm_cnt;
        logic [1:0]  mstate;
        logic [3:0]  mcycle;
        logic        done;
        logic        wsvc;
        logic        wcont;
        logic        tb_latch;
        logic        ack;
        logic [31:0] rdata;
    } scmc_state_s;

    scmc_state_s st_q;
    scmc_state_s st_d;

    logic                            fc_tick;
    logic                            fs_tick;
    logic                            pre_clear;
    logic                            pre_in;
    logic                            pre_out;
    logic [`SCMC_PRE_STAGES-1:0]     pre_stages;
    logic [`SCMC_DIV_LO_STAGES-1:0]  lo_stages;
    logic                            lo_out;
    logic [`SCMC_DIV_HI_STAGES-1:0]  hi_stages;
    logic                            st7_in;
    logic                            slow_mode;
    logic                            main_tick;
    logic                            tb_src;
    logic                            access;
    logic                            wr_en;
    logic [4:0]                      tb_idx;

    // ============================================================
    // Clock pin edges, taken after the two-flop synchronisers
    assign fc_tick = st_q.hi_sync[1] & ~st_q.hi_sync[2];
    assign fs_tick = st_q.lo_sync[1] & ~st_q.lo_sync[2];

    assign slow_mode = (st_q.mode == SCMC_SLOW_DUAL_RUN) ||
                       (st_q.mode == SCMC_SLOW_LOW_ONLY) ||
                       (st_q.mode == SCMC_SLEEP);

    // ============================================================
    // Prescaler and divider chain
    // Cleared throughout STOP and warm-up entry edges [RQ2]
    assign pre_clear = (st_q.mode == SCMC_STOP) || (st_d.mode == SCMC_STOP) ||
                       (st_d.mode == SCMC_WARMUP && st_q.mode != SCMC_WARMUP);
    // Low stages stand still in slow modes
    assign pre_in    = fc_tick & ~slow_mode & high_osc_run;

    always_comb begin
        // Stage seven source [RQ3]
        if (slow_mode) begin
            st7_in = fs_tick; // [RQ4]
        end else if (st_q.mode == SCMC_WARMUP && st_q.warm_fast) begin
            st7_in = lo_out; // [RQ5]
        end else if (st_q.stage_seven_clock_select) begin
            st7_in = fs_tick;
        end else begin
            st7_in = lo_out;
        end
    end

    // Two-stage prescaler, then six plus fifteen divider stages [RQ1]
    scmc_divider #(.STAGES(`SCMC_PRE_STAGES)) u_prescaler (
        .clk      (clk),
        .rst_b    (rst_b),
        .clear    (pre_clear),
        .tick_in  (pre_in),
        .stages   (pre_stages),
        .tick_out (pre_out)
    );

    scmc_divider #(.STAGES(`SCMC_DIV_LO_STAGES)) u_div_low (
        .clk      (clk),
        .rst_b    (rst_b),
        .clear    (pre_clear),
        .tick_in  (pre_out),
        .stages   (lo_stages),
        .tick_out (lo_out)
    );

    scmc_divider #(.STAGES(`SCMC_DIV_HI_STAGES)) u_div_high (
        .clk      (clk),
        .rst_b    (rst_b),
        .clear    (pre_clear),
        .tick_in  (st7_in),
        .stages   (hi_stages),
        .tick_out ()
    );

    assign divider_stages = {hi_stages, lo_stages};

    // Time-base source: every second stage from the base upward
    assign tb_idx = 5'(`SCMC_TB_BASE_STAGE + 2 * st_q.time_base_source_select);
    assign tb_src = divider_stages[tb_idx];

    // Main clock: fc in fast modes, fs in slow ones [RQ10] [RQ17] [RQ18]
    assign main_tick = slow_mode ? fs_tick : fc_tick;

    // ============================================================
    // Register bus: one wait cycle, answer on the following edge
    assign access      = read | write;
    assign waitrequest = access & ~st_q.ack;
    assign wr_en       = write & st_q.ack;

    // ============================================================
    // Next state
    always_comb begin
        st_d          = st_q;
        st_d.hi_sync  = {st_q.hi_sync[1:0], high_crystal_in};
        st_d.lo_sync  = {st_q.lo_sync[1:0], low_crystal_in};
        st_d.rel_sync = {st_q.rel_sync[0], stop_release_pin};
        st_d.tb_prev  = tb_src;
        st_d.done     = 1'b0;
        st_d.wsvc     = 1'b0;
        st_d.wcont    = 1'b0;
        st_d.ack      = access & ~st_q.ack;

        if (access && !st_q.ack) begin
            case (address)
                `SCMC_OFS_CTRL2: st_d.rdata = {24'h0,
                    st_q.high_osc_enable, st_q.low_osc_enable, st_q.main_clock_select,
                    st_q.idle_req, 1'b0, st_q.timing_gen_halt, 2'h0};
                `SCMC_OFS_TBCTRL: st_d.rdata = {24'h0, st_q.time_base_enable, 2'h0,
                    st_q.stage_seven_clock_select, 1'b0, st_q.time_base_source_select};
                `SCMC_OFS_CTRL1: st_d.rdata = {24'h0, st_q.stop_req, 1'b0,
                    st_q.ret_slow, 5'h0};
                `SCMC_OFS_STATUS: st_d.rdata = {24'h0, st_q.tb_latch, 1'b0,
                    st_q.mstate, st_q.mode};
                default: st_d.rdata = 32'h0;
            endcase
        end

        if (wr_en) begin
            case (address)
                `SCMC_OFS_CTRL2: begin
                    st_d.high_osc_enable   = writedata[`SCMC_BIT_HIGH_OSC];
                    st_d.low_osc_enable    = writedata[`SCMC_BIT_LOW_OSC];
                    st_d.main_clock_select = writedata[`SCMC_BIT_MAIN_SEL];
                    st_d.idle_req          = writedata[`SCMC_BIT_IDLE];
                    st_d.timing_gen_halt   = writedata[`SCMC_BIT_TG_HALT];
                end
                `SCMC_OFS_TBCTRL: begin
                    st_d.time_base_enable         = writedata[`SCMC_BIT_TB_EN];
                    // Left to software: single-clock and stability limits [RQ6] [RQ7]
                    st_d.stage_seven_clock_select = writedata[`SCMC_BIT_DV7_SEL];
                    st_d.time_base_source_select  = writedata[`SCMC_TB_SRC_MSB:0];
                end
                `SCMC_OFS_CTRL1: begin
                    st_d.stop_req = writedata[`SCMC_BIT_STOP];
                    st_d.ret_slow = writedata[`SCMC_BIT_RET_SLOW];
                end
                `SCMC_OFS_STATUS: begin
                    // Write one clears the latch
                    if (writedata[7]) begin
                        st_d.tb_latch = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Machine cycle: four states per cycle, counted only while the CPU runs
        if (main_tick && cpu_clock_enable) begin
            st_d.mstate = st_q.mstate + 2'h1; // [RQ8]
            if (st_q.mstate == 2'(`SCMC_STATES_PER_MC - 1)) begin
                if (st_q.mcycle + 4'h1 >= instr_cycles ||
                    st_q.mcycle == 4'(`SCMC_MAX_INSTR_MC - 1)) begin
                    st_d.mcycle = 4'h0; // [RQ9]
                    st_d.done   = 1'b1;
                end else begin
                    st_d.mcycle = st_q.mcycle + 4'h1;
                end
            end
        end

        case (st_q.mode)
            SCMC_FAST_SINGLE_RUN: begin
                if (st_q.stop_req) begin
                    st_d.mode      = SCMC_STOP;
                    st_d.warm_fast = 1'b1;
                end else if (st_q.timing_gen_halt) begin
                    st_d.mode    = SCMC_DEEP_IDLE; // [RQ14]
                    st_d.tb_pend = st_q.time_base_enable; // [RQ16]
                end else if (st_q.idle_req) begin
                    st_d.mode = SCMC_FAST_SINGLE_IDLE; // [RQ12]
                end else if (st_q.low_osc_enable) begin
                    st_d.mode = SCMC_FAST_DUAL_RUN; // [RQ17]
                end
                st_d.ret_mode = SCMC_FAST_SINGLE_RUN;
            end
            SCMC_FAST_DUAL_RUN: begin
                if (st_q.stop_req) begin
                    st_d.mode      = SCMC_STOP;
                    st_d.warm_fast = 1'b1;
                end else if (st_q.idle_req) begin
                    st_d.mode = SCMC_FAST_DUAL_IDLE;
                end else if (st_q.main_clock_select) begin
                    st_d.mode = SCMC_SLOW_DUAL_RUN; // [RQ20]
                end else if (!st_q.low_osc_enable) begin
                    st_d.mode = SCMC_FAST_SINGLE_RUN;
                end
                st_d.ret_mode = SCMC_FAST_DUAL_RUN;
            end
            SCMC_SLOW_DUAL_RUN: begin
                // Low oscillator kept on by software here [RQ22]
                if (st_q.stop_req) begin
                    st_d.mode      = SCMC_STOP;
                    st_d.warm_fast = 1'b0;
                end else if (st_q.idle_req) begin
                    st_d.mode = SCMC_SLEEP;
                end else if (!st_q.main_clock_select) begin
                    st_d.mode = SCMC_FAST_DUAL_RUN; // [RQ20]
                end else if (!st_q.high_osc_enable) begin
                    st_d.mode = SCMC_SLOW_LOW_ONLY; // [RQ21]
                end
                st_d.ret_mode = SCMC_SLOW_DUAL_RUN;
            end
            SCMC_SLOW_LOW_ONLY: begin
                if (st_q.stop_req) begin
                    st_d.mode      = SCMC_STOP;
                    st_d.warm_fast = 1'b0;
                end else if (st_q.idle_req) begin
                    st_d.mode = SCMC_SLEEP;
                end else if (st_q.high_osc_enable) begin
                    st_d.mode = SCMC_SLOW_DUAL_RUN;
                end
                st_d.ret_mode = SCMC_SLOW_LOW_ONLY;
            end
            SCMC_FAST_SINGLE_IDLE, SCMC_FAST_DUAL_IDLE, SCMC_SLEEP: begin
                if (irq_pending) begin
                    st_d.mode     = st_q.ret_mode; // [RQ13]
                    st_d.idle_req = 1'b0;
                    st_d.wsvc     = interrupt_master_enable;
                    st_d.wcont    = ~interrupt_master_enable;
                end
            end
            SCMC_DEEP_IDLE: begin
                // Resume on the falling edge of the time-base source [RQ14]
                if (st_q.tb_prev && !tb_src) begin
                    st_d.mode            = SCMC_FAST_SINGLE_RUN; // [RQ15]
                    st_d.timing_gen_halt = 1'b0;
                    st_d.tb_latch        = st_d.tb_latch | st_q.tb_pend; // [RQ16]
                    st_d.wsvc            = interrupt_master_enable & time_base_int_enable &
                                           st_q.time_base_enable; // [RQ15]
                    st_d.wcont           = ~(interrupt_master_enable & time_base_int_enable &
                                             st_q.time_base_enable);
                    st_d.tb_pend         = 1'b0;
                end
            end
            SCMC_STOP: begin
                st_d.warm_cnt = WARMUP_CYCLES;
                if (st_q.rel_sync[1]) begin
                    st_d.mode     = SCMC_WARMUP;
                    st_d.stop_req = 1'b0;
                end
            end
            SCMC_WARMUP: begin
                if (st_q.warm_cnt <= 16'h1) begin
                    st_d.mode = st_q.ret_slow ? SCMC_SLOW_LOW_ONLY : st_q.ret_mode;
                    st_d.high_osc_enable = ~st_q.ret_slow | st_q.high_osc_enable;
                end else begin
                    st_d.warm_cnt = st_q.warm_cnt - 16'h1;
                end
            end
            default: begin
                st_d.mode = SCMC_FAST_SINGLE_RUN;
            end
        endcase
    end

    // ============================================================
    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q                          <= '0;
            st_q.mode                     <= SCMC_FAST_SINGLE_RUN; // [RQ11]
            st_q.ret_mode                 <= SCMC_FAST_SINGLE_RUN;
            st_q.high_osc_enable          <= 1'(`SCMC_RST_CTRL2 >> `SCMC_BIT_HIGH_OSC);
            st_q.time_base_enable         <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ============================================================
    // Outputs
    assign readdata            = st_q.rdata;
    assign machine_state       = st_q.mstate;
    assign instr_done          = st_q.done;
    assign wake_service        = st_q.wsvc;
    assign wake_continue       = st_q.wcont;
    assign time_base_int_latch = st_q.tb_latch;
    // Single-clock: low oscillator off, its pins free as ports [RQ10]
    assign low_osc_run         = (st_q.mode == SCMC_FAST_DUAL_RUN) ||
                                 (st_q.mode == SCMC_FAST_DUAL_IDLE) || slow_mode;
    assign low_pins_as_port    = ~low_osc_run;
    assign high_osc_run        = (st_q.mode != SCMC_STOP) &&
                                 (st_q.mode != SCMC_SLOW_LOW_ONLY) &&
                                 !(st_q.mode == SCMC_SLEEP && !st_q.high_osc_enable);
    assign cpu_clock_enable    = (st_q.mode == SCMC_FAST_SINGLE_RUN) ||
                                 (st_q.mode == SCMC_FAST_DUAL_RUN) ||
                                 (st_q.mode == SCMC_SLOW_DUAL_RUN) ||
                                 (st_q.mode == SCMC_SLOW_LOW_ONLY);
    assign periph_clock_enable = (st_q.mode != SCMC_DEEP_IDLE) &&
                                 (st_q.mode != SCMC_STOP) &&
                                 (st_q.mode != SCMC_WARMUP);

endmodule

// ### tb/scmc_checker.sv
// Port assertions of the clock mode controller.
// Assumes a bind into scmc_top and one clock.
`timescale 1ns/1ps
module scmc_checker
    import scmc_pkg::*;
(
    input wire logic        clk, rst_b, irq_pending, interrupt_master_enable,
    input wire logic        high_osc_run, low_osc_run, low_pins_as_port,
    input wire logic        cpu_clock_enable, periph_clock_enable,
    input wire logic        instr_done, wake_service, wake_continue,
    input wire logic [1:0]  machine_state,
    input wire logic [20:0] divider_stages
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ============================================================
    // Mode and timing relations
    ports_follow_a: assert property (low_pins_as_port == !low_osc_run)
        else $error("port flag wrong");
    single_high_a: assert property (low_pins_as_port && cpu_clock_enable |-> high_osc_run)
        else $error("no high osc");
    state_step_a: assert property ($changed(machine_state) |->
        machine_state == $past(machine_state) + 2'h1)
        else $error("state skip");
    done_pulse_a: assert property (instr_done |=> !instr_done)
        else $error("long done");
    // Deep idle wakes on the time base, with no request
    wake_serve_a: assert property (wake_service |-> $past(interrupt_master_enable) &&
        ($past(irq_pending) || !$past(periph_clock_enable)))
        else $error("bad service wake");
    wake_cont_a: assert property (wake_continue |-> !$past(periph_clock_enable) ||
        ($past(irq_pending) && !$past(interrupt_master_enable)))
        else $error("bad continue wake");
    halt_cpu_a: assert property (!periph_clock_enable |-> !cpu_clock_enable)
        else $error("cpu in halt");
    stop_clear_a: assert property (!high_osc_run && !low_osc_run |-> divider_stages == 21'h0)
        else $error("divider set");
    slow_low_a: assert property (!high_osc_run && cpu_clock_enable |-> low_osc_run)
        else $error("no oscillator");
    cover property (wake_service);
    cover property (wake_continue);
    cover property ($fell(periph_clock_enable));
endmodule
bind scmc_top scmc_checker chk_u (.*);

// ### tb/scmc_xtal_model.sv
// Both crystals as slow clock pins.
// Assumes the run outputs gate each one.
`timescale 1ns/1ps
module scmc_xtal_model (
    input  wire logic clk,
    input  wire logic high_en,
    input  wire logic low_en,
    output logic      high_pin = 1'b0,
    output logic      low_pin = 1'b0
);
    logic [3:0] cnt_q = 4'h0;
    // ============================================================
    // Stopped oscillator holds its level
    always @(posedge clk) begin
        cnt_q <= cnt_q + 4'h1;
        if (high_en && cnt_q[0]) high_pin <= !high_pin;
        if (low_en && cnt_q == 4'hf) low_pin <= !low_pin;
    end
endmodule

// ### tb/test_system_clock_mode_controller.sv
// Self-checking bench of the clock mode controller.
// Assumes the model ticks high every 4 clk, low every 32.
`timescale 1ns/1ps
`include "scmc_defs.svh"
module test_system_clock_mode_controller
    import scmc_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, stop_pin = 1'b0;
    logic ime = 1'b0, tbie = 1'b0, irq = 1'b0, wreq, hi, lo, hrun, lrun, lport;
    logic cpu_en, per_en, done, wsrv, wcon, latch;
    logic [3:0] address = 4'h0, icyc = 4'h3;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic [1:0] mstate;
    logic [20:0] div;
    int fail_count = 0, comparisons = 0;
    always #5 clk = !clk;
    scmc_top #(.WARMUP_CYCLES(16'd4)) dut_u (.*,
        .waitrequest(wreq), .high_crystal_in(hi), .low_crystal_in(lo),
        .stop_release_pin(stop_pin), .interrupt_master_enable(ime),
        .time_base_int_enable(tbie), .irq_pending(irq), .instr_cycles(icyc),
        .high_osc_run(hrun), .low_osc_run(lrun), .low_pins_as_port(lport),
        .cpu_clock_enable(cpu_en), .periph_clock_enable(per_en), .machine_state(mstate),
        .instr_done(done), .wake_service(wsrv), .wake_continue(wcon),
        .time_base_int_latch(latch), .divider_stages(div));
    scmc_xtal_model xtal_u (.clk(clk), .high_en(hrun), .low_en(lrun), .high_pin(hi),
        .low_pin(lo));
    // ============================================================
    // Shared tasks
    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do @(posedge clk); while (wreq !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task mode(input scmc_mode_e m, input int lim);
        for (int n = 0; n < lim; n++) begin
            bus(0, `SCMC_OFS_STATUS, 0);
            if (rd[3:0] === m) break;
        end
        check(rd[3:0], m);
    endtask
    task gap(input int exp, input logic on_done);
        int n;
        logic [1:0] s;
        for (int k = 0; k < 2; k++) begin
            s = mstate;
            n = 0;
            do begin @(posedge clk); n++; end
            while ((on_done ? done !== 1'b1 : mstate === s) && n < 999);
        end
        check(n, exp);
    endtask
    // ============================================================
    // Scenarios
    task t_reset;
        bus(0, `SCMC_OFS_CTRL2, 0);
        check(rd, {24'h0, `SCMC_RST_CTRL2});
        bus(0, 4'h2, 0);
        check(rd, 0);
        mode(SCMC_FAST_SINGLE_RUN, 1);
        check({hrun, lport, cpu_en}, 3'h7);
        gap(4, 0);
        icyc <= 4'h1;
        gap(16, 1);
        icyc <= 4'ha;
        gap(160, 1);
        $display("reset done");
    endtask
    task t_idle(input logic en);
        ime <= en;
        bus(1, `SCMC_OFS_CTRL2, 32'h90);
        mode(SCMC_FAST_SINGLE_IDLE, 1);
        check({cpu_en, per_en}, 2'h1);
        irq <= 1'b1;
        @(posedge clk);
        #1 check({wsrv, wcon}, {en, !en});
        irq <= 1'b0;
        @(posedge clk);
        mode(SCMC_FAST_SINGLE_RUN, 1);
        $display("idle done");
    endtask
    task t_deep;
        tbie <= 1'b1;
        bus(1, `SCMC_OFS_TBCTRL, 32'h80);
        bus(1, `SCMC_OFS_CTRL2, 32'h84);
        mode(SCMC_DEEP_IDLE, 1);
        check({cpu_en, per_en}, 2'h0);
        mode(SCMC_FAST_SINGLE_RUN, 1000);
        check(latch, 1);
        bus(1, `SCMC_OFS_STATUS, 32'h80);
        bus(1, `SCMC_OFS_TBCTRL, 32'h00);
        bus(1, `SCMC_OFS_CTRL2, 32'h84);
        mode(SCMC_FAST_SINGLE_RUN, 1000);
        check(latch, 0);
        $display("deep done");
    endtask
    task t_stop;
        bus(1, `SCMC_OFS_CTRL1, 32'h80);
        mode(SCMC_STOP, 1);
        check(div, 0);
        stop_pin <= 1'b1;
        mode(SCMC_FAST_SINGLE_RUN, 50);
        stop_pin <= 1'b0;
        $display("stop done");
    endtask
    task t_dual;
        // Low oscillator first
        bus(1, `SCMC_OFS_CTRL2, 32'hc0);
        mode(SCMC_FAST_DUAL_RUN, 1);
        check({lrun, lport}, 2'h2);
        bus(1, `SCMC_OFS_CTRL2, 32'he0);
        mode(SCMC_SLOW_DUAL_RUN, 1);
        bus(1, `SCMC_OFS_CTRL2, 32'h60);
        mode(SCMC_SLOW_LOW_ONLY, 1);
        check(hrun, 0);
        gap(32, 0);
        bus(1, `SCMC_OFS_CTRL2, 32'he0);
        bus(1, `SCMC_OFS_CTRL2, 32'hc0);
        mode(SCMC_FAST_DUAL_RUN, 1);
        $display("dual done");
    endtask
    task summarize;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset;
        t_idle(1);
        t_idle(0);
        t_deep;
        t_stop;
        t_dual;
        summarize;
    end
    initial begin
        #300000;
        fail_count++;
        summarize;
    end
endmodule
